/* hdl/fsh_cmd_core.sv */
/*
  Serial flash command interpreter: fast array read, two identification
  reads, write enable latch set and clear, parallel mode entry and exit.
  Assumes the serial clock runs at no more than an eighth of clk_sys and
  that the array answers mem_addr with mem_data within one clk_sys cycle.
*/
`timescale 1ns/1ps
module fsh_cmd_core #(
  parameter logic [7:0] ID_MANUF  = 8'h5a, // Arbitrary value.
  parameter logic [7:0] ID_DEV0   = 8'hc3, // Arbitrary value.
  parameter logic [7:0] ID_DEV1   = 8'h3c, // Arbitrary value.
  parameter logic [7:0] ID_EXT0   = 8'ha5, // Arbitrary value.
  parameter logic [7:0] ID_EXT1   = 8'h96, // Arbitrary value.
  parameter logic [7:0] ID_ADDRD  = 8'h69  // Arbitrary value.
) (
  // Clock and reset.
  input  wire logic                           clk_sys,
  input  wire logic                           nrst,
  // Link pins, serial and byte-wide.
  input  wire logic                           sck,
  input  wire logic                           cs_n,
  input  wire logic                           si,
  output logic                                so,
  output logic                                so_oe,
  output logic [fsh_pkg::BYTE_BITS-1:0]       parallel_out_bus,
  output logic                                par_oe,
  // Memory array read port.
  output logic [fsh_pkg::ADDR_BITS-1:0]       mem_addr,
  input  wire logic [fsh_pkg::BYTE_BITS-1:0]  mem_data,
  // Write engine status.
  input  wire logic                           operation_busy_flag,
  input  wire logic                           op_done,
  // Device state.
  output logic                                write_enable_latch,
  output logic                                parallel_mode,
  output logic                                standby,
  output logic [1:0]                          status_bits
);

  import fsh_pkg::*;

  // ******************************************************************
  // Link sampling
  // ******************************************************************
  logic [2:0] sync_q;
  logic       sck_q;
  logic       cs_n_q;
  logic       sck_s;
  logic       cs_n_s;
  logic       si_s;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_fall;
  logic       cs_rise;

  fsh_sync #(.WIDTH(3)) u_sync (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .async_in ({si, ~cs_n, sck}),
    .sync_out (sync_q)
  );

  // Select is synchronised active high so reset reads as deselected.
  assign sck_s    = sync_q[0];
  assign cs_n_s   = ~sync_q[1];
  assign si_s     = sync_q[2];
  assign sck_rise = sck_s & ~sck_q & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_q & ~cs_n_s;
  assign cs_fall  = ~cs_n_s & cs_n_q;
  assign cs_rise  = cs_n_s & ~cs_n_q;

  // Previous levels for edge detection.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sck_q  <= 1'b0;
      cs_n_q <= 1'b1;
    end
    else
    begin
      sck_q  <= sck_s;
      cs_n_q <= cs_n_s;
    end
  end

  // ******************************************************************
  // Command sequencing
  // ******************************************************************
  fsh_state_t state;
  logic [4:0] cnt;
  logic [7:0] in_sr;
  logic [7:0] opcode;
  logic [7:0] in_byte;
  logic [2:0] bit_mod;
  logic       whole_byte;
  logic       id_seen;
  logic       byte_ok;

  assign in_byte = {in_sr[6:0], si_s};
  assign byte_ok = whole_byte && (bit_mod == 3'h0);

  // Input shift register, msb first on rising edges.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      in_sr <= BYTE_RST;
    else if (sck_rise)
      in_sr <= in_byte;
  end

  // Clock count modulo eight, for the byte boundary check at deselect.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      bit_mod    <= 3'h0;
      whole_byte <= 1'b0;
    end
    else if (cs_fall)
    begin
      bit_mod    <= 3'h0;
      whole_byte <= 1'b0;
    end
    else if (sck_rise)
    begin
      bit_mod <= bit_mod + 3'h1;
      if (bit_mod == 3'h7)
        whole_byte <= 1'b1;
    end
  end

  // Main sequencer; chip select rising ends any sequence at once.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state   <= ST_IDLE;
      cnt     <= 5'h00;
      opcode  <= BYTE_RST;
      id_seen <= 1'b0;
    end
    else if (cs_n_s)
    begin
      state <= ST_IDLE;
      cnt   <= 5'h00;
    end
    else if (cs_fall)
    begin
      state   <= ST_OPCODE;
      cnt     <= 5'h00;
      opcode  <= BYTE_RST;
      id_seen <= 1'b0;
    end
    else if (sck_rise)
    begin
      cnt <= cnt + 5'h01;
      unique case (state)
        ST_OPCODE:
        begin
          if (cnt == LAST_BYTE_BIT)
          begin
            opcode <= in_byte;
            cnt    <= 5'h00;
            state  <= ST_IGNORE;
            if (in_byte == OPC_FAST_READ && !operation_busy_flag
                && !parallel_mode)
              state <= ST_ADDR;
            else if (in_byte == OPC_ADDR_ID)
            begin
              state   <= ST_ADDR;
              id_seen <= 1'b1;
            end
            else if (in_byte == OPC_JEDEC_ID && !operation_busy_flag)
            begin
              state   <= ST_DATA;
              id_seen <= 1'b1;
            end
            else if (in_byte == OPC_SIG_ID)
              id_seen <= 1'b1;
          end
        end
        ST_ADDR:
        begin
          if (cnt == LAST_ADDR_BIT)
          begin
            cnt   <= 5'h00;
            state <= (opcode == OPC_FAST_READ) ? ST_DUMMY : ST_DATA;
          end
        end
        ST_DUMMY:
        begin
          if (cnt == LAST_BYTE_BIT)
          begin
            cnt   <= 5'h00;
            state <= ST_DATA;
          end
        end
        ST_DATA:
          cnt <= {2'b00, cnt[2:0] + 3'h1};
        ST_IGNORE:
          cnt <= 5'h00;
        ST_IDLE:
          cnt <= 5'h00;
      endcase
    end
  end

  // ******************************************************************
  // Output data path
  // ******************************************************************
  logic [23:0] addr_sr;
  logic [2:0]  jedec_idx;
  logic        id_sel;
  logic [7:0]  out_sr;
  logic [7:0]  next_byte;
  logic [2:0]  jedec_len;
  logic        load;

  assign jedec_len = parallel_mode ? JEDEC_LEN_PAR : JEDEC_LEN_SER;
  // A new byte is due on every fall in parallel mode, else every eighth.
  assign load = (state == ST_DATA) && sck_fall
                && (parallel_mode || cnt[2:0] == 3'h0);

  // Byte selection for the running command.
  always_comb
  begin
    next_byte = BYTE_RST;
    if (opcode == OPC_FAST_READ)
      next_byte = mem_data;
    else if (opcode == OPC_ADDR_ID)
      next_byte = id_sel ? ID_ADDRD : ID_MANUF;
    else if (jedec_idx < jedec_len)
    begin
      unique case (jedec_idx)
        3'h0: next_byte = ID_MANUF;
        3'h1: next_byte = ID_DEV0;
        3'h2: next_byte = ID_DEV1;
        3'h3: next_byte = ID_EXT0;
        default: next_byte = ID_EXT1;
      endcase
    end
  end

  // Address capture and read address advance.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      addr_sr  <= 24'h000000;
      mem_addr <= 24'h000000;
    end
    else if (sck_rise && state == ST_ADDR)
    begin
      addr_sr <= {addr_sr[22:0], si_s};
      if (cnt == LAST_ADDR_BIT)
        mem_addr <= {addr_sr[22:0], si_s};
    end
    else if (load && opcode == OPC_FAST_READ)
      mem_addr <= mem_addr + 24'h000001;
  end

  // Identification sequencing; 90h toggles forever from bit 0.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      jedec_idx <= 3'h0;
      id_sel    <= 1'b0;
    end
    else if (cs_fall)
      jedec_idx <= 3'h0;
    else if (sck_rise && state == ST_ADDR && cnt == LAST_ADDR_BIT)
      id_sel <= si_s;
    else if (load)
    begin
      id_sel <= ~id_sel;
      if (jedec_idx < JEDEC_LEN_SER)
        jedec_idx <= jedec_idx + 3'h1;
    end
  end

  // Serial and parallel data change only on falling clock edges; enables drop outside ST_DATA.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      out_sr           <= BYTE_RST;
      so_oe            <= 1'b0;
      parallel_out_bus <= BYTE_RST;
      par_oe           <= 1'b0;
    end
    else if (state != ST_DATA)
    begin
      so_oe  <= 1'b0;
      par_oe <= 1'b0;
    end
    else if (load && parallel_mode)
    begin
      parallel_out_bus <= next_byte;
      par_oe           <= 1'b1;
    end
    else if (load)
    begin
      out_sr <= next_byte;
      so_oe  <= 1'b1;
    end
    else if (sck_fall && !parallel_mode)
      out_sr <= {out_sr[6:0], 1'b0};
  end

  assign so = out_sr[7];

  // ******************************************************************
  // Device state flags
  // ******************************************************************
  logic latch_set;
  logic latch_clr;

  assign latch_set = cs_rise && byte_ok && opcode == OPC_LATCH_SET;
  assign latch_clr = (cs_rise && byte_ok && opcode == OPC_LATCH_CLR)
                     || op_done;

  // Write enable latch; a set in the same cycle as a clear wins.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      write_enable_latch <= 1'b0;
    else if (latch_set)
      write_enable_latch <= 1'b1;
    else if (latch_clr)
      write_enable_latch <= 1'b0;
  end

  // Parallel mode flag.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      parallel_mode <= 1'b0;
    else if (cs_rise && byte_ok && opcode == OPC_PAR_ENTER)
      parallel_mode <= 1'b1;
    else if (cs_rise && byte_ok && opcode == OPC_PAR_EXIT)
      parallel_mode <= 1'b0;
  end

  // Standby after an identification command from deselect, cleared on reselect.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      standby <= 1'b0;
    else if (cs_rise && id_seen)
      standby <= 1'b1;
    else if (cs_fall)
      standby <= 1'b0;
  end

  // Low status bits: busy from the write engine, and the latch.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      status_bits <= 2'b00;
    else
    begin
      status_bits[STAT_BUSY_BIT]  <= operation_busy_flag;
      status_bits[STAT_LATCH_BIT] <= write_enable_latch;
    end
  end

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_latch_set;
    latch_set |=> write_enable_latch ##1 status_bits[STAT_LATCH_BIT];
  endproperty
  a_latch_set: assert property (p_latch_set)
    else $error("latch not set by set command");

  property p_latch_clr;
    (latch_clr && !latch_set) |=> !write_enable_latch;
  endproperty
  a_latch_clr: assert property (p_latch_clr)
    else $error("latch not cleared");

  property p_partial_byte;
    (cs_rise && !byte_ok && !op_done) |=> $stable(write_enable_latch);
  endproperty
  a_partial_byte: assert property (p_partial_byte)
    else $error("latch changed on partial byte");

  property p_deselect_ends;
    cs_rise |-> ##[1:2] (!so_oe && !par_oe && state == ST_IDLE);
  endproperty
  a_deselect_ends: assert property (p_deselect_ends)
    else $error("outputs still driven after deselect");

  property p_busy_reject;
    (state == ST_OPCODE && sck_rise && cnt == LAST_BYTE_BIT
     && operation_busy_flag) |=> state != ST_DATA && state != ST_DUMMY
     && !(state == ST_ADDR && opcode == OPC_FAST_READ);
  endproperty
  a_busy_reject: assert property (p_busy_reject)
    else $error("read decoded while busy");

  property p_par_no_fast;
    parallel_mode && state == ST_ADDR |-> opcode != OPC_FAST_READ;
  endproperty
  a_par_no_fast: assert property (p_par_no_fast)
    else $error("fast read accepted in parallel mode");

  property p_so_on_fall;
    !sck_fall |=> $stable(so);
  endproperty
  a_so_on_fall: assert property (p_so_on_fall)
    else $error("serial output changed off a falling edge");

  property p_addr_wrap;
    (load && opcode == OPC_FAST_READ && mem_addr == 24'hffffff)
      |=> mem_addr == 24'h000000;
  endproperty
  a_addr_wrap: assert property (p_addr_wrap)
    else $error("read address did not wrap");

  property p_standby;
    (cs_rise && id_seen) |=> standby until cs_fall;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby not held after id command");

endmodule // fsh_cmd_core

/* hdl/fsh_sync.sv */
/*
  Two-stage synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level from outside the clk_sys domain.
*/
`timescale 1ns/1ps
module fsh_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      meta     <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // fsh_sync

/* pkg/fsh_pkg.sv */
/*
  Constants, opcodes and state codes for the serial flash command block.
  Assumes a single system clock domain that oversamples the serial link.
*/
package fsh_pkg;

  localparam int ADDR_BITS = 24;
  localparam int BYTE_BITS = 8;
  localparam logic [7:0] OPC_FAST_READ = 8'h0b;
  localparam logic [7:0] OPC_JEDEC_ID  = 8'h9f;
  localparam logic [7:0] OPC_ADDR_ID   = 8'h90;
  localparam logic [7:0] OPC_SIG_ID    = 8'hab;
  localparam logic [7:0] OPC_LATCH_SET = 8'h06;
  localparam logic [7:0] OPC_LATCH_CLR = 8'h04;
  localparam logic [7:0] OPC_PAR_ENTER = 8'h55;
  localparam logic [7:0] OPC_PAR_EXIT  = 8'h45;
  localparam logic [2:0] JEDEC_LEN_SER = 3'h5;
  localparam logic [2:0] JEDEC_LEN_PAR = 3'h3;
  localparam logic [4:0] LAST_BYTE_BIT = 5'h07;
  localparam logic [4:0] LAST_ADDR_BIT = 5'h17;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_LATCH_BIT = 1;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ADDR   = 3'b010,
    ST_DUMMY  = 3'b011,
    ST_DATA   = 3'b100,
    ST_IGNORE = 3'b101
  } fsh_state_t;

endpackage

/* verif/fsh_host.sv */
/*
  Host model for the serial flash command block: drives the link pins
  and captures the serial or byte-wide answer.
  Assumes clk_sys at 40 MHz; sck runs at 5 MHz in mode 0.
*/
`timescale 1ns/1ps
module fsh_host (
  // Clock.
  input  wire logic       clk_sys,
  // Link pins.
  output logic            sck,
  output logic            cs_n,
  output logic            si,
  input  wire logic       so,
  input  wire logic       so_oe,
  input  wire logic [7:0] parallel_out_bus,
  input  wire logic       par_oe
);
  logic oe_seen;

  // Link idles deselected with the clock standing low.
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    oe_seen = 1'b0;
  end

  // Waits n falling edges of clk_sys.
  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // One frame: ntx bits msb first, then nrx clocks of capture.
  // Half period of 4 cycles keeps sck at 5 MHz
  task automatic frame(input logic [39:0] tx, input int ntx,
                       input int nrx, input bit par,
                       output logic [63:0] rx);
    rx = '0;
    oe_seen = 1'b0;
    cs_n = 1'b0;
    hold(4);
    for (int i = 0; i < ntx + nrx; i++)
    begin
      // Don't-care input bits toggle so they never look stable.
      si = (i < ntx) ? tx[ntx-1-i] : ~si;
      hold(4);
      sck = 1'b1;
      hold(4);
      if (i >= ntx)
        rx = par ? {rx[55:0], parallel_out_bus} : {rx[62:0], so};
      oe_seen = oe_seen | so_oe | par_oe;
      sck = 1'b0;
    end
    hold(4);
    cs_n = 1'b1;
    si = ~si;
    hold(8);
  endtask

  // Clock pulses while deselected, which the device must ignore.
  task automatic stray(input int n);
    repeat (n)
    begin
      si = ~si;
      hold(4);
      sck = 1'b1;
      hold(4);
      sck = 1'b0;
    end
    hold(4);
  endtask
endmodule // fsh_host

/* verif/tb_top.sv */
/*
  Self-checking bench for the serial flash command block.
  Assumes fsh_pkg and the host model fsh_host are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import fsh_pkg::*;

  localparam logic [7:0] M  = 8'h3e; // Arbitrary value.
  localparam logic [7:0] D0 = 8'h71; // Arbitrary value.
  localparam logic [7:0] D1 = 8'h2d; // Arbitrary value.
  localparam logic [7:0] E0 = 8'hb4; // Arbitrary value.
  localparam logic [7:0] E1 = 8'h8e; // Arbitrary value.
  localparam logic [7:0] AD = 8'hd2; // Arbitrary value.

  logic        clk_sys, nrst, sck, cs_n, si, so, so_oe, par_oe;
  logic        operation_busy_flag, op_done, write_enable_latch;
  logic        parallel_mode, standby;
  logic [7:0]  parallel_out_bus, mem_data;
  logic [23:0] mem_addr, a;
  logic [1:0]  status_bits;
  logic [63:0] rx;
  int          miscompares, n_tests, cycles, nrx;

  // Array contents are a fixed mix of the address bytes.
  function automatic logic [7:0] mem_f(input logic [23:0] ad);
    return ad[23:16] ^ ad[15:8] ^ ad[7:0] ^ 8'h5c;
  endfunction

  // Expected stream of n array bytes from ad, wrapping at the top.
  function automatic logic [63:0] exp_rd(input logic [23:0] ad,
                                         input int n);
    exp_rd = '0;
    for (int i = 0; i < n; i++)
      exp_rd = {exp_rd[55:0], mem_f(ad + 24'(i))};
  endfunction

  assign mem_data = mem_f(mem_addr);

  fsh_cmd_core #(.ID_MANUF(M), .ID_DEV0(D0), .ID_DEV1(D1),
                 .ID_EXT0(E0), .ID_EXT1(E1), .ID_ADDRD(AD)) dut (
    .clk_sys, .nrst, .sck, .cs_n, .si, .so, .so_oe,
    .parallel_out_bus, .par_oe, .mem_addr, .mem_data,
    .operation_busy_flag, .op_done, .write_enable_latch,
    .parallel_mode, .standby, .status_bits);

  fsh_host host (.clk_sys, .sck, .cs_n, .si, .so, .so_oe,
                 .parallel_out_bus, .par_oe);

  // Free-running 40 MHz system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Prints the verdict and ends the run.
  task automatic report_and_stop;
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Cuts a hang short well beyond the expected run length.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  // Main sequence.
  initial
  begin
    nrst = 1'b0;
    operation_busy_flag = 1'b0;
    op_done = 1'b0;
    void'($urandom(46));
    repeat (12) @(negedge clk_sys);
    check({so_oe, par_oe, write_enable_latch, parallel_mode, standby,
           mem_addr}, '0);
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    // Latch set and clear, with a broken byte count and stray clocks.
    host.frame(40'(OPC_LATCH_SET), 8, 0, 0, rx);
    check(write_enable_latch, 1'b1);
    check(status_bits, 2'b10);
    host.frame(40'(OPC_LATCH_CLR), 8, 0, 0, rx);
    check(write_enable_latch, 1'b0);
    host.frame(40'({OPC_LATCH_SET, 4'h0}), 12, 0, 0, rx);
    check(write_enable_latch, 1'b0);
    host.stray(3);
    host.frame(40'(OPC_LATCH_SET), 8, 0, 0, rx);
    check(write_enable_latch, 1'b1);
    op_done = 1'b1;
    @(negedge clk_sys);
    op_done = 1'b0;
    repeat (3) @(negedge clk_sys);
    check(write_enable_latch, 1'b0);
    // Fast reads: top-address wrap, then random starts cut mid-byte.
    for (int k = 0; k < 4; k++)
    begin
      a = (k == 0) ? 24'hffffff : 24'($urandom);
      nrx = (k == 0) ? 24 : 8 + 5 * k;
      host.frame({OPC_FAST_READ, a, 8'($urandom)}, 40, nrx, 0, rx);
      check(rx, exp_rd(a, 3) >> (24 - nrx));
      check(so_oe, 1'b0);
    end
    // Reads refused while the write engine is busy.
    operation_busy_flag = 1'b1;
    host.frame({OPC_FAST_READ, 32'h0}, 40, 8, 0, rx);
    check(host.oe_seen, 1'b0);
    check(status_bits, 2'b01);
    host.frame(40'(OPC_JEDEC_ID), 8, 8, 0, rx);
    check(host.oe_seen, 1'b0);
    operation_busy_flag = 1'b0;
    // Serial identification reads.
    host.frame(40'(OPC_JEDEC_ID), 8, 48, 0, rx);
    check(rx, {16'h0, M, D0, D1, E0, E1, 8'h00});
    check(standby, 1'b1);
    for (int b = 0; b < 2; b++)
    begin
      a = {23'($urandom), b[0]};
      host.frame({OPC_ADDR_ID, a}, 32, 32, 0, rx);
      check(rx, b ? {32'h0, AD, M, AD, M}
                  : {32'h0, M, AD, M, AD});
    end
    host.frame(40'(OPC_LATCH_SET), 8, 0, 0, rx);
    check(standby, 1'b0);
    // Parallel mode entry, byte-wide id, refused fast read, exit.
    host.frame(40'(OPC_PAR_ENTER), 8, 0, 0, rx);
    check(parallel_mode, 1'b1);
    host.frame(40'(OPC_JEDEC_ID), 8, 4, 1, rx);
    check(rx, {32'h0, M, D0, D1, 8'h00});
    host.frame({OPC_FAST_READ, 32'h0}, 40, 8, 1, rx);
    check(host.oe_seen, 1'b0);
    host.frame(40'(OPC_PAR_EXIT), 8, 0, 0, rx);
    check(parallel_mode, 1'b0);
    report_and_stop();
  end
endmodule // tb_top
